// ---- sdrd_core.sv ----
// sdram device core: activation, read/write bursts, mode register, apb view
// assumes a controller keeps tRCD, tRC, tRRD, tRP and cl-1 placement
//
// Decided for this implementation: the APB register port and the address map.
`include "sdrd_cfg.svh"

module sdrd_core #(
  parameter int MEM_ROW_BITS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sdrd_pkg::sdrd_cmd_t cmd,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic [3:0] dq_oe
);
  import sdrd_pkg::*;

  localparam int IDXW = 2 + MEM_ROW_BITS + 8;

  // storage holds only the low row bits; upper rows alias by design
  logic [31:0] mem [0:(1<<IDXW)-1];

  function automatic logic [7:0] bl_mask(input logic [2:0] bl);
    case (bl)
      `SDRD_BL_1: bl_mask = 8'h00;
      `SDRD_BL_2: bl_mask = 8'h01;
      `SDRD_BL_4: bl_mask = 8'h03;
      `SDRD_BL_8: bl_mask = 8'h07;
      `SDRD_BL_PAGE: bl_mask = 8'hFF;
      default: bl_mask = 8'h00;
    endcase
  endfunction

  // block chosen by high bits, position inside by low bits
  function automatic logic [7:0] burst_col(input logic [7:0] start,
    input logic [7:0] k, input logic [7:0] mask, input logic ilv);
    logic [7:0] sum;
    sum = start + k;
    burst_col = ilv ? (start ^ (k & mask)) : ((start & ~mask) | (sum & mask));
  endfunction

  function automatic logic [IDXW-1:0] mem_idx(input logic [1:0] bank,
    input logic [11:0] row, input logic [7:0] col);
    mem_idx = {bank, row[MEM_ROW_BITS-1:0], col};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // state
  sdrd_mode_t mode_ff;
  sdrd_eng_t eng_ff;
  sdrd_eng_t nxt_eng;
  logic [1:0] eng_bank_ff;
  logic [7:0] eng_col_ff;
  logic [7:0] eng_k_ff;
  logic eng_ap_ff;
  logic bank_open_ff [4];
  logic [11:0] row_ff [4];
  sdrd_rd_t pipe_ff [2];
  logic [3:0] dqm_d1_ff;
  logic [31:0] dq_out_ff;
  logic [3:0] dq_oe_ff;
  logic [`SDRD_ERR_W-1:0] err_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  //////////////////////////////////////////////////////////////////////////
  // command decode
  wire sdrd_op_t op = cmd.cs_n ? SDRD_OP_NOP
                    : sdrd_op_t'({cmd.ras_n, cmd.cas_n, cmd.we_n});
  wire [1:0] cba = cmd.ba;
  // refresh decodes to nothing: cell contents never decay here
  wire bank_is_open = bank_open_ff[cba];
  wire is_rw = (op == SDRD_OP_RD) | (op == SDRD_OP_WR);
  wire rw_idle = is_rw & ~bank_is_open;
  wire eng_busy = (eng_ff != SDRD_ENG_IDLE);
  wire rd_inflight = pipe_ff[0].valid | pipe_ff[1].valid | (|dq_oe_ff)
                   | (eng_ff == SDRD_ENG_RD);
  // write over a live read without prior mask is dropped
  wire wr_bad = (op == SDRD_OP_WR) & bank_is_open & rd_inflight
              & (dqm_d1_ff != `SDRD_DQM_ALL);
  wire new_rd = (op == SDRD_OP_RD) & bank_is_open;
  wire new_wr = (op == SDRD_OP_WR) & bank_is_open & ~wr_bad;
  wire new_rw = new_rd | new_wr;
  wire pre_all = (op == SDRD_OP_PRE) & cmd.addr[`SDRD_AP_BIT];
  wire pre_hit = (op == SDRD_OP_PRE)
               & (cmd.addr[`SDRD_AP_BIT] | (cba == eng_bank_ff));
  wire stop_now = (op == SDRD_OP_BST) | pre_hit;

  //////////////////////////////////////////////////////////////////////////
  // burst engine: one column issued per edge
  wire iss_valid = new_rw | (eng_busy & ~stop_now);
  wire iss_wr = new_rw ? new_wr : (eng_ff == SDRD_ENG_WR);
  wire single_wr = iss_wr & mode_ff.wb;
  wire iss_page = (mode_ff.bl == `SDRD_BL_PAGE) & ~single_wr;
  wire [7:0] iss_mask = single_wr ? `SDRD_COL_ZERO
                      : bl_mask(mode_ff.bl);
  wire [1:0] iss_bank = new_rw ? cba : eng_bank_ff;
  wire [7:0] iss_start = new_rw ? cmd.addr[7:0] : eng_col_ff;
  wire [7:0] iss_k = new_rw ? `SDRD_COL_ZERO : eng_k_ff;
  // auto precharge never applies to page bursts
  wire iss_ap = new_rw ? (cmd.addr[`SDRD_AP_BIT] & ~iss_page) : eng_ap_ff;
  wire [7:0] iss_col = burst_col(iss_start, iss_k, iss_mask, mode_ff.bt);
  wire iss_last = iss_valid & ~iss_page & (iss_k == iss_mask);
  wire ap_close = iss_last & iss_ap;
  wire ap_cut = eng_busy & eng_ap_ff & (stop_now | new_rw);
  wire [7:0] nxt_k = iss_k + 8'h01; // page wraps to zero

  always_comb begin
    case (eng_ff)
      SDRD_ENG_IDLE, SDRD_ENG_RD, SDRD_ENG_WR: begin
        if (iss_valid && !iss_last) begin
          nxt_eng = iss_wr ? SDRD_ENG_WR : SDRD_ENG_RD;
        end else begin
          nxt_eng = SDRD_ENG_IDLE;
        end
      end
      default: nxt_eng = SDRD_ENG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_ff <= SDRD_ENG_IDLE;
      eng_bank_ff <= 2'h0;
      eng_col_ff <= 8'h00;
      eng_k_ff <= 8'h00;
      eng_ap_ff <= 1'b0;
    end else begin
      eng_ff <= nxt_eng;
      eng_bank_ff <= iss_bank;
      eng_col_ff <= iss_start;
      eng_k_ff <= nxt_k;
      eng_ap_ff <= iss_ap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-bank open state and row
  logic [3:0] bank_act;
  logic [3:0] bank_close;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      assign bank_act[b] = (op == SDRD_OP_ACT) & (cba == 2'(b));
      assign bank_close[b] = pre_all
                           | ((op == SDRD_OP_PRE) & (cba == 2'(b)))
                           | (ap_close & (iss_bank == 2'(b)))
                           | (ap_cut & (eng_bank_ff == 2'(b)));
    end
  endgenerate

  // one process owns all bank flags, so each has a single driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        bank_open_ff[i] <= 1'b0;
        row_ff[i] <= 12'h000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bank_act[i]) begin
          bank_open_ff[i] <= 1'b1;
          row_ff[i] <= cmd.addr;
        end else if (bank_close[i]) begin
          bank_open_ff[i] <= 1'b0;
        end
      end
    end
  end

  wire [3:0] open_vec = {bank_open_ff[3], bank_open_ff[2],
                         bank_open_ff[1], bank_open_ff[0]};

  //////////////////////////////////////////////////////////////////////////
  // write path: mask on inputs has no latency
  always_ff @(posedge pclk) begin
    if (iss_valid && iss_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (!cmd.dqm[i]) begin
          mem[mem_idx(iss_bank, row_ff[iss_bank], iss_col)][8*i +: 8]
            <= dq_in[8*i +: 8];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read pipe: output flop loads at edge n+m-1, valid at n+m
  wire sdrd_rd_t rd_now = '{valid: iss_valid & ~iss_wr,
                             bank: iss_bank, col: iss_col};
  wire sdrd_rd_t src = (mode_ff.cl == `SDRD_CL_1) ? rd_now
                     : (mode_ff.cl == `SDRD_CL_2) ? pipe_ff[0]
                     : pipe_ff[1];
  wire [31:0] rd_word = mem[mem_idx(src.bank, row_ff[src.bank], src.col)];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_ff[0] <= '0;
      pipe_ff[1] <= '0;
      dqm_d1_ff <= 4'h0;
      dq_out_ff <= 32'h0000_0000;
      dq_oe_ff <= 4'h0;
    end else begin
      dqm_d1_ff <= cmd.dqm;
      dq_out_ff <= rd_word;
      if (new_wr) begin
        pipe_ff[0] <= '0;
        pipe_ff[1] <= '0;
        dq_oe_ff <= 4'h0;
      end else begin
        pipe_ff[0] <= rd_now;
        pipe_ff[1] <= pipe_ff[0];
        // no element means release mask seen two edges on
        dq_oe_ff <= {4{src.valid}} & ~dqm_d1_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write takes effect at the pready edge
  wire sel_mode = (paddr == `SDRD_OFS_MODE);
  wire sel_stat = (paddr == `SDRD_OFS_STAT);
  wire sel_err = (paddr == `SDRD_OFS_ERR);
  wire hit = sel_mode | sel_stat | sel_err;
  // status and error words are local views; unused bits read zero
  wire apb_done = psel & penable & pready_ff;
  wire apb_wr = apb_done & pwrite;
  wire op_err = (mode_ff.op != `SDRD_OP_NORMAL);
  wire [31:0] rd_val = sel_mode ? {22'h00_0000, mode_ff}
                     : sel_stat ? {26'h000_0000, op_err, eng_busy, open_vec}
                     : sel_err ? {30'h0000_0000, err_ff}
                     : 32'h0000_0000;
  wire [`SDRD_ERR_W-1:0] err_set = {wr_bad, rw_idle};
  wire [`SDRD_ERR_W-1:0] err_clr = (apb_wr & sel_err)
                                 ? pwdata[`SDRD_ERR_W-1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `SDRD_MODE_RST;
      err_ff <= 2'h0;
    end else begin
      if (op == SDRD_OP_LMR) begin
        mode_ff <= sdrd_mode_t'(cmd.addr[`SDRD_MR_HI:0]);
      end else if (apb_wr && sel_mode) begin
        mode_ff <= sdrd_mode_t'(pwdata[`SDRD_MR_HI:0]);
      end
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      if (psel && penable && !pready_ff) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_ff <= ~hit;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe = dq_oe_ff;
endmodule // sdrd_core

// ---- sdrd_cfg.svh ----
// sdram read/activate device: offsets, reset values and field codes
// assumes inclusion by the core only; types live in sdrd_pkg
`ifndef SDRD_CFG_SVH
`define SDRD_CFG_SVH
`define SDRD_OFS_MODE 8'h00
`define SDRD_OFS_STAT 8'h04
`define SDRD_OFS_ERR 8'h08
// cas latency 2, burst of one, sequential, normal operation
`define SDRD_MODE_RST 10'h020
`define SDRD_BL_1 3'h0
`define SDRD_BL_2 3'h1
`define SDRD_BL_4 3'h2
`define SDRD_BL_8 3'h3
`define SDRD_BL_PAGE 3'h7
`define SDRD_CL_1 3'h1
`define SDRD_CL_2 3'h2
`define SDRD_OP_NORMAL 2'h0
`define SDRD_AP_BIT 10
`define SDRD_MR_HI 9
`define SDRD_ERR_W 2
`define SDRD_DQM_ALL 4'hF
`define SDRD_COL_ZERO 8'h00
`endif

// ---- sdrd_pkg.sv ----
// sdram read/activate device: shared types
// assumes the command pins are sampled on the rising edge of pclk
package sdrd_pkg;
  // command code {ras_n, cas_n, we_n} when selected
  typedef enum logic [2:0] {
    SDRD_OP_LMR = 3'h0,
    SDRD_OP_REF = 3'h1,
    SDRD_OP_PRE = 3'h2,
    SDRD_OP_ACT = 3'h3,
    SDRD_OP_WR = 3'h4,
    SDRD_OP_RD = 3'h5,
    SDRD_OP_BST = 3'h6,
    SDRD_OP_NOP = 3'h7
  } sdrd_op_t;
  typedef enum logic [2:0] {
    SDRD_ENG_IDLE = 3'h1,
    SDRD_ENG_RD = 3'h2,
    SDRD_ENG_WR = 3'h4
  } sdrd_eng_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [3:0] dqm;
  } sdrd_cmd_t;
  typedef struct packed {
    logic wb;
    logic [1:0] op;
    logic [2:0] cl;
    logic bt;
    logic [2:0] bl;
  } sdrd_mode_t;
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [7:0] col;
  } sdrd_rd_t;
endpackage

// ---- sdrd_properties.sv ----
// checker: apb handshake and data-pin timing of sdrd_core
// assumes cas latency changes only by mode writes or mode loads
module sdrd_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sdrd_pkg::sdrd_cmd_t cmd,
  input wire logic [3:0] dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdrd_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [2:0] cl_ff;
  logic [2:0] nxt_cl;
  wire [2:0] op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  wire is_rd = !cmd.cs_n && op == SDRD_OP_RD;
  wire is_wr = !cmd.cs_n && op == SDRD_OP_WR;
  wire done = psel && penable && pready;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08};
  wire mode_wr = done && pwrite && paddr == 8'h00;
  // a mode load wins over a bus write in the same cycle
  assign nxt_cl = (!cmd.cs_n && op == SDRD_OP_LMR) ? cmd.addr[6:4] :
    mode_wr ? pwdata[6:4] : cl_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cl_ff <= 3'h2;
    else
      cl_ff <= nxt_cl;
  end
  //////////////////////////////////////////////////////////////////////
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_xfer: assert property (pready |-> psel && penable)
    else $error("pready outside a transfer");
  a_err_unmapped: assert property (done |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_zero_data: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("read data not zero on error");
  a_mask_two_clk: assert property (
    cmd.dqm != 4'h0 |-> ##2 (dq_oe & $past(cmd.dqm, 2)) == 4'h0)
    else $error("masked lane still driven");
  a_write_hiz: assert property (
    is_wr && $past(cmd.dqm) == 4'hF |=> dq_oe == 4'h0)
    else $error("data lines driven after write");
  a_oe_after_read: assert property (
    $past(dq_oe) == 4'h0 && dq_oe != 4'h0 && $past(cmd.dqm, 3) == 4'h0
    |-> (cl_ff == 3'h1 ? $past(is_rd) :
      cl_ff == 3'h2 ? $past(is_rd, 2) : $past(is_rd, 3)))
    else $error("drive began off the cas latency");
  c_read: cover property (is_rd ##2 dq_oe == 4'hF);
  c_apb_err: cover property (done && pslverr);
  c_wr_trunc: cover property (is_wr && $past(cmd.dqm) == 4'hF);
endmodule // sdrd_properties

bind sdrd_core sdrd_properties u_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd(cmd), .dq_oe(dq_oe));

// ---- sdrd_ctrl_model.sv ----
// memory controller stand-in: one command per clock on the pins
// assumes the bench sequences it through cyc, nop, act, pre, lmr
module sdrd_ctrl_model #(
  parameter int TRCD = 2,
  parameter int TRP = 2
) (
  input wire logic pclk,
  output sdrd_pkg::sdrd_cmd_t cmd,
  output logic [31:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdrd_pkg::*;
  logic [3:0] open_bank; // banks this controller believes are open
  initial begin
    cmd = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    dq_in = 32'h0000_0000;
    open_bank = 4'h0;
  end
  task automatic cyc(input sdrd_op_t op, input logic [1:0] ba,
    input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
    @(posedge pclk);
    cmd <= '{1'b0, op[2], op[1], op[0], ba, a, m};
    dq_in <= d;
  endtask
  // released bus: inverse of last value, never a stale copy
  task automatic nop();
    cyc(SDRD_OP_NOP, 2'h0, 12'h000, 4'h0, ~dq_in);
  endtask
  task automatic act(input logic [1:0] ba, input logic [11:0] row);
    cyc(SDRD_OP_ACT, ba, row, 4'h0, ~dq_in);
    repeat (TRCD) nop();
    open_bank[ba] = 1'b1;
  endtask
  task automatic pre(input logic [1:0] ba);
    cyc(SDRD_OP_PRE, ba, 12'h000, 4'h0, ~dq_in);
    repeat (TRP) nop();
    open_bank[ba] = 1'b0;
  endtask
  task automatic lmr(input logic [9:0] v);
    cyc(SDRD_OP_LMR, 2'h0, {2'h0, v[9], 2'h0, v[6:0]}, 4'h0, ~dq_in);
    nop();
  endtask
endmodule // sdrd_ctrl_model

// ---- sdrd_core_tb_top.sv ----
// testbench: apb register view and read/write bursts of sdrd_core
// assumes sdrd_ctrl_model drives the command pins
`define SDRD_CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("mismatch %s exp %h got %h", nm, ex, got); \
    end \
  end
module sdrd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdrd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dq_in, dq_out;
  logic [3:0] dq_oe;
  sdrd_cmd_t cmd;
  int mismatches = 0;
  int n_compared = 0;
  int cl_cyc = 2; // read latency in clocks, follows each mode load
  sdrd_core #(.MEM_ROW_BITS(2)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd(cmd), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  sdrd_ctrl_model u_ctl (.pclk(pclk), .cmd(cmd), .dq_in(dq_in));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] dv(input logic [7:0] c);
    return {16'hC0DE, 8'h00, c};
  endfunction
  task automatic rc(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] ex, input logic exe);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    `SDRD_CHK("pslverr", exe, pslverr)
    if (!w)
      `SDRD_CHK("prdata", ex, prdata)
    {psel, penable} <= 2'b00;
  endtask
  // read at col, optional second command op2 at cycle k, check stream
  task automatic rd(input logic [7:0] col, input sdrd_op_t op2,
    input logic [11:0] a2, input int k, input logic [31:0] e[$]);
    int n;
    n = e.size();
    u_ctl.cyc(SDRD_OP_RD, 2'h0, {4'h0, col}, 4'h0, ~dq_in);
    for (int i = 1; i <= n + cl_cyc; i++) begin
      if (i == k)
        u_ctl.cyc(op2, 2'h0, a2, 4'h0, ~dq_in);
      else
        u_ctl.nop();
      #1;
      if (i >= cl_cyc)
        `SDRD_CHK("dq_oe", (i - cl_cyc < n) ? 4'hF : 4'h0, dq_oe)
      if (i >= cl_cyc && i - cl_cyc < n)
        `SDRD_CHK("dq_out", e[i-cl_cyc], dq_out)
    end
  endtask
  task automatic wr(input logic [7:0] col, input logic [31:0] d[$]);
    u_ctl.cyc(SDRD_OP_WR, 2'h0, {4'h0, col}, 4'h0, d[0]);
    for (int i = 1; i < d.size(); i++)
      u_ctl.cyc(SDRD_OP_NOP, 2'h0, 12'h000, 4'h0, d[i]);
    u_ctl.nop();
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_bl1();
    rc(1'b0, 8'h00, 32'h0, 32'h0000_0020, 1'b0);
    rc(1'b1, 8'h0C, 32'h0000_FFFF, 32'h0, 1'b1);
    u_ctl.act(2'h0, 12'h001);
    for (int c = 4; c < 8; c++)
      wr(8'(c), {dv(8'(c))});
    wr(8'hFF, {dv(8'hFF)});
    wr(8'h00, {dv(8'h00)});
    rd(8'h04, SDRD_OP_RD, 12'h005, 1, {dv(4), dv(5)});
    u_ctl.pre(2'h0);
  endtask
  task automatic t_bl4();
    u_ctl.lmr(10'h022);
    u_ctl.act(2'h0, 12'h001);
    wr(8'h08, {dv(8), dv(9), dv(10), dv(11)});
    rd(8'h0A, SDRD_OP_NOP, 12'h000, 0, {dv(10), dv(11), dv(8), dv(9)});
    rd(8'h04, SDRD_OP_RD, 12'h006, 2,
      {dv(4), dv(5), dv(6), dv(7), dv(4), dv(5)});
    rd(8'h08, SDRD_OP_PRE, 12'h000, 2, {dv(8), dv(9)});
    repeat (2) u_ctl.nop();
    u_ctl.act(2'h0, 12'h001);
    rc(1'b1, 8'h00, 32'h0000_0222, 32'h0, 1'b0);
    wr(8'h08, {dv(1), dv(2)});
    rd(8'h08, SDRD_OP_NOP, 12'h000, 0, {dv(1), dv(9), dv(10), dv(11)});
    u_ctl.pre(2'h0);
  endtask
  task automatic t_page();
    u_ctl.lmr(10'h027);
    u_ctl.act(2'h0, 12'h001);
    rd(8'hFF, SDRD_OP_BST, 12'h000, 2, {dv(8'hFF), dv(0)});
    u_ctl.cyc(SDRD_OP_RD, 2'h0, 12'h004, 4'h0, ~dq_in);
    u_ctl.cyc(SDRD_OP_NOP, 2'h0, 12'h000, 4'hF, ~dq_in);
    u_ctl.cyc(SDRD_OP_NOP, 2'h0, 12'h000, 4'hF, ~dq_in);
    #1;
    `SDRD_CHK("dq_out", dv(4), dq_out)
    u_ctl.cyc(SDRD_OP_WR, 2'h0, 12'h010, 4'h0, 32'h1234_5678);
    #1;
    `SDRD_CHK("dq_oe", 4'h0, dq_oe)
    repeat (3) u_ctl.nop();
    #1;
    `SDRD_CHK("dq_oe", 4'h0, dq_oe)
    rd(8'h10, SDRD_OP_BST, 12'h000, 1, {32'h1234_5678});
  endtask
  task automatic t_err();
    u_ctl.cyc(SDRD_OP_RD, 2'h3, 12'h004, 4'h0, ~dq_in);
    repeat (4) u_ctl.nop();
    #1;
    `SDRD_CHK("dq_oe", 4'h0, dq_oe)
    u_ctl.cyc(SDRD_OP_RD, 2'h0, 12'h004, 4'h0, ~dq_in);
    u_ctl.nop();
    u_ctl.cyc(SDRD_OP_WR, 2'h0, 12'h010, 4'h0, 32'hDEAD_BEEF);
    u_ctl.cyc(SDRD_OP_BST, 2'h0, 12'h000, 4'h0, ~dq_in);
    repeat (3) u_ctl.nop();
    rc(1'b0, 8'h08, 32'h0, 32'h0000_0003, 1'b0);
    rc(1'b1, 8'h08, 32'h0000_0003, 32'h0, 1'b0);
    rc(1'b0, 8'h08, 32'h0, 32'h0000_0000, 1'b0);
    rc(1'b0, 8'h04, 32'h0, {28'h000_0000, u_ctl.open_bank}, 1'b0);
  endtask
  // interleaved order at latency three, then auto precharge closes the bank
  task automatic t_ilv();
    u_ctl.pre(2'h0);
    u_ctl.lmr(10'h03A);
    cl_cyc = 3;
    u_ctl.act(2'h0, 12'h001);
    // column 8 still holds the single-location write
    rd(8'h09, SDRD_OP_NOP, 12'h000, 0,
      {dv(9), dv(1), dv(11), dv(10)});
    u_ctl.cyc(SDRD_OP_RD, 2'h0, 12'h409, 4'h0, ~dq_in);
    repeat (6) u_ctl.nop();
    rc(1'b0, 8'h04, 32'h0, 32'h0000_0000, 1'b0);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (6000) @(posedge pclk);
    mismatches++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_bl1();
    t_bl4();
    t_page();
    t_err();
    t_ilv();
    close_out();
  end
endmodule // sdrd_core_tb_top
